// *** core/usmi_top.sv ***
`timescale 1ns/1ps
`include "usmi_cfg.svh"

module usmi_top
    import usmi_pkg::*;
(
    // clock and reset
    input  wire logic          sys_clk,
    input  wire logic          rst_n,
    // register port
    input  wire usmi_req_type  busReq,
    output logic [31:0]        busRdata,
    // serial engine side
    input  wire usmi_evt_type  lineEvt,
    input  wire logic          ctsPin,
    input  wire logic          extClkPin,
    // configuration and control outputs
    output usmi_mode_type      opMode,
    output logic [1:0]         baudSource,
    output logic [3:0]         dataBits,
    output logic               baudTick,
    output logic               rxEnable,
    output logic               txEnable,
    output logic [8:0]         txChar,
    output logic               txCharValid,
    output logic               breakRequest,
    // interrupt
    output logic               irq
);

    //------------------------------------------------------------
    // register port decode
    //------------------------------------------------------------
    logic        wrCtrl, wrMode, wrIen, wrIdis, wrTx, rdFlags, rdRx;
    logic [31:0] modeReg, maskReg, flagsNow;
    logic [8:0]  rxChar;

    // strobes qualified by address
    assign wrCtrl  = busReq.wr && (busReq.addr == `USMI_OFS_CTRL);
    assign wrMode  = busReq.wr && (busReq.addr == `USMI_OFS_MODE);
    assign wrIen   = busReq.wr && (busReq.addr == `USMI_OFS_IEN);
    assign wrIdis  = busReq.wr && (busReq.addr == `USMI_OFS_IDIS);
    assign wrTx    = busReq.wr && (busReq.addr == `USMI_OFS_TXDATA);
    assign rdFlags = busReq.rd && (busReq.addr == `USMI_OFS_FLAGS);
    assign rdRx    = busReq.rd && (busReq.addr == `USMI_OFS_RXDATA);

    //------------------------------------------------------------
    // pin synchronisers
    //------------------------------------------------------------
    logic ctsMeta, ctsSync, ctsLast;
    logic extMeta, extSync, extLast;

    // two flops per pin, then one more for edge detect
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctsMeta <= 1'b0;
            ctsSync <= 1'b0;
            ctsLast <= 1'b0;
            extMeta <= 1'b0;
            extSync <= 1'b0;
            extLast <= 1'b0;
        end
        else
        begin
            ctsMeta <= ctsPin;
            ctsSync <= ctsMeta;
            ctsLast <= ctsSync;
            extMeta <= extClkPin;
            extSync <= extMeta;
            extLast <= extSync;
        end
    end

    //------------------------------------------------------------
    // mode register and decode
    //------------------------------------------------------------
    // only documented fields are kept; others read zero
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            modeReg <= 32'h00000000;
        else if (wrMode)
            modeReg <= busReq.wdata & `USMI_MODE_VALID;
    end

    // mode field to operating mode
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            opMode <= USMI_NORMAL;
        else
        begin
            case (modeReg[`USMI_F_MODE_HI:`USMI_F_MODE_LO])
                `USMI_M_NORMAL:  opMode <= USMI_NORMAL;
                `USMI_M_RS485:   opMode <= USMI_RS485;
                `USMI_M_HSHAKE:  opMode <= USMI_HSHAKE;
                `USMI_M_ISO_T0:  opMode <= USMI_ISO_T0;
                `USMI_M_ISO_T1:  opMode <= USMI_ISO_T1;
                `USMI_M_IRDA:    opMode <= USMI_IRDA;
                `USMI_M_SPI_MST: opMode <= USMI_SPI_MASTER;
                `USMI_M_SPI_SLV: opMode <= USMI_SPI_SLAVE;
                default:         opMode <= USMI_RESERVED;
            endcase
        end
    end

    // character length, nine-bit overrides the field
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            dataBits <= `USMI_BITS_BASE;
        else if (modeReg[`USMI_F_NINE])
            dataBits <= `USMI_BITS_NINE;
        else
            dataBits <= `USMI_BITS_BASE + {2'h0, modeReg[`USMI_F_CHAR_LENGTH_SEL_HI:`USMI_F_CHAR_LENGTH_SEL_LO]};
    end

    //------------------------------------------------------------
    // baud clock source
    //------------------------------------------------------------
    logic [2:0] divCount;

    // free-running fixed divider
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            divCount <= 3'h0;
        else
            divCount <= divCount + 3'h1;
    end

    // one enable pulse per selected source edge; reserved gives none
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            baudTick   <= 1'b0;
            baudSource <= `USMI_S_INT;
        end
        else
        begin
            baudSource <= modeReg[`USMI_F_SRC_HI:`USMI_F_SRC_LO];
            case (modeReg[`USMI_F_SRC_HI:`USMI_F_SRC_LO])
                `USMI_S_INT: baudTick <= 1'b1;
                `USMI_S_DIV: baudTick <= (divCount == `USMI_DIV_LAST);
                `USMI_S_EXT: baudTick <= extSync && !extLast;
                default:     baudTick <= 1'b0;
            endcase
        end
    end

    //------------------------------------------------------------
    // control commands: enables, break, transmit holding
    //------------------------------------------------------------
    // disable wins over enable in the same write
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rxEnable <= 1'b0;
            txEnable <= 1'b0;
        end
        else if (wrCtrl)
        begin
            if (busReq.wdata[`USMI_C_RXDIS])
                rxEnable <= 1'b0;
            else if (busReq.wdata[`USMI_C_RXEN])
                rxEnable <= 1'b1;
            if (busReq.wdata[`USMI_C_TXDIS])
                txEnable <= 1'b0;
            else if (busReq.wdata[`USMI_C_TXEN])
                txEnable <= 1'b1;
        end
    end

    // holding register; a new write beats a same-cycle load
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            txChar      <= 9'h000;
            txCharValid <= 1'b0;
        end
        else if (wrTx)
        begin
            txChar      <= busReq.wdata[8:0];
            txCharValid <= 1'b1;
        end
        else if (lineEvt.txLoaded)
            txCharValid <= 1'b0;
    end

    // break request held until the engine starts it or tx is disabled
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            breakRequest <= 1'b0;
        else if (wrCtrl && busReq.wdata[`USMI_C_BRK])
            breakRequest <= 1'b1;
        else if (lineEvt.breakStarted || !txEnable)
            breakRequest <= 1'b0;
    end

    //------------------------------------------------------------
    // status flags
    //------------------------------------------------------------
    logic clrErr, rxReady, txReady, ctsEdge;
    logic parFlag, frameFlag, ovrFlag, brkFlag, manFlag, retryFlag;

    assign clrErr = wrCtrl && busReq.wdata[`USMI_C_CLRERR];

    // error flags: set wins over the clear command
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            parFlag   <= 1'b0;
            frameFlag <= 1'b0;
            ovrFlag   <= 1'b0;
            brkFlag   <= 1'b0;
            manFlag   <= 1'b0;
            retryFlag <= 1'b0;
        end
        else
        begin
            parFlag   <= lineEvt.parity     || (parFlag   && !clrErr);
            frameFlag <= lineEvt.framing    || (frameFlag && !clrErr);
            ovrFlag   <= lineEvt.overrun    || (ovrFlag   && !clrErr);
            brkFlag   <= lineEvt.breakSeen  || (brkFlag   && !clrErr);
            manFlag   <= lineEvt.manchester || (manFlag   && !clrErr);
            retryFlag <= lineEvt.retryLimit || (retryFlag && !clrErr);
        end
    end

    // cts change: any edge sets, a status read clears
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            ctsEdge <= 1'b0;
        else
            ctsEdge <= (ctsSync ^ ctsLast) || (ctsEdge && !rdFlags);
    end

    // rx ready; a character arriving during the read is kept
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rxReady <= 1'b0;
            rxChar  <= 9'h000;
        end
        else if (lineEvt.charDone && rxEnable)
        begin
            rxReady <= 1'b1;
            rxChar  <= lineEvt.charData;
        end
        else if (rdRx || !rxEnable)
            rxReady <= 1'b0;
    end

    // tx ready from holding, break and enable state
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            txReady <= 1'b0;
        else
            txReady <= txEnable && !txCharValid && !breakRequest;
    end

    // status word assembly; unused bits read zero
    always_comb
    begin
        flagsNow                  = 32'h00000000;
        flagsNow[`USMI_B_RX_CHAR_WAITING]   = rxReady;
        flagsNow[`USMI_B_TX_HOLDING_FREE]   = txReady;
        flagsNow[`USMI_B_BRK]     = brkFlag;
        flagsNow[`USMI_B_RX_DMA_DONE]   = lineEvt.rxDmaDone;
        flagsNow[`USMI_B_TX_DMA_DONE]   = lineEvt.txDmaDone;
        flagsNow[`USMI_B_OVR]     = ovrFlag;
        flagsNow[`USMI_B_FRAME]   = frameFlag;
        flagsNow[`USMI_B_PAR]     = parFlag;
        flagsNow[`USMI_B_TOUT]    = lineEvt.timeout;
        flagsNow[`USMI_B_TX_FULLY_DRAINED] = lineEvt.txDrained && txEnable;
        flagsNow[`USMI_B_RETRY]   = retryFlag;
        flagsNow[`USMI_B_TX_DMA_BUF_EMPTY]  = lineEvt.txDmaEmpty;
        flagsNow[`USMI_B_RX_DMA_BUF_FULL]  = lineEvt.rxDmaFull;
        flagsNow[`USMI_B_ISO_NEGATIVE_ACK]    = lineEvt.iso_negative_ack;
        flagsNow[`USMI_B_CTS_EDGE_SEEN]   = ctsEdge;
        flagsNow[`USMI_B_CTS]     = ctsSync;
        flagsNow[`USMI_B_MANCHESTER_FAULT_FLAG]  = manFlag;
    end

    //------------------------------------------------------------
    // interrupt mask and output
    //------------------------------------------------------------
    // set and clear by ones only; zeros leave bits alone
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            maskReg <= 32'h00000000;
        else if (wrIen)
            maskReg <= maskReg | (busReq.wdata & `USMI_IRQ_VALID);
        else if (wrIdis)
            maskReg <= maskReg & ~busReq.wdata;
    end

    // manchester flag is gated by either of its two mask bits
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            irq <= 1'b0;
        else
            irq <= (|(flagsNow & maskReg)) || (manFlag && maskReg[`USMI_B_MANCHESTER_FAULT_IRQ]);
    end

    //------------------------------------------------------------
    // read data, valid only the cycle after the strobe
    //------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            busRdata <= 32'h00000000;
        else if (!busReq.rd)
            busRdata <= 32'h00000000;
        else if (busReq.addr == `USMI_OFS_MODE)
            busRdata <= modeReg;
        else if (busReq.addr == `USMI_OFS_IVIEW)
            busRdata <= maskReg;
        else if (busReq.addr == `USMI_OFS_FLAGS)
            busRdata <= flagsNow;
        else if (busReq.addr == `USMI_OFS_RXDATA)
            busRdata <= {23'h0, rxChar};
        else
            busRdata <= 32'h00000000; // write-only and unmapped read zero
    end

endmodule : usmi_top

// *** core/usmi_cfg.svh ***
//----------------------------------------------------------------
// serial port mode and interrupt status constants
//----------------------------------------------------------------
// Function
// - mode field codes normal, rs485, handshake, iso t0/t1, irda, spi master/slave
// - clock source 00 internal, 01 divided, 11 external pin, 10 reserved
// - enable register write sets valid mask bits written as one
// - disable register write clears mask bits written as one
// - mask register reads enabled sources, zero after reset
// - bits 0-7 are rx ready, tx ready, break, dma ends, errors
// - bits 8-13 are timeout, tx empty, retry, dma buffers, iso_negative_ack
// - manchester fault mask at bits 20 and 24, flag at 24
// - cts change source sits at bit 19
// - manchester flag sticky until clear-error command
// - status bit 23 shows present cts pin level
// - separate sources for rx dma full and tx dma empty
// - clear-error command clears parity, framing, overrun, manchester, break
// - cts change flag set on any edge, cleared by status read
// - rx ready set by full character, cleared by data read or disable
// - tx ready low when char waiting, break pending or tx disabled
`ifndef USMI_CFG_SVH
`define USMI_CFG_SVH

// register offsets
`define USMI_OFS_CTRL     8'h00
`define USMI_OFS_MODE     8'h04
`define USMI_OFS_IEN      8'h08
`define USMI_OFS_IDIS     8'h0c
`define USMI_OFS_IVIEW    8'h10
`define USMI_OFS_FLAGS    8'h14
`define USMI_OFS_RXDATA   8'h18
`define USMI_OFS_TXDATA   8'h1c

// status and mask bit positions
`define USMI_B_RX_CHAR_WAITING      0
`define USMI_B_TX_HOLDING_FREE      1
`define USMI_B_BRK        2
`define USMI_B_RX_DMA_DONE      3
`define USMI_B_TX_DMA_DONE      4
`define USMI_B_OVR        5
`define USMI_B_FRAME      6
`define USMI_B_PAR        7
`define USMI_B_TOUT       8
`define USMI_B_TX_FULLY_DRAINED    9
`define USMI_B_RETRY      10
`define USMI_B_TX_DMA_BUF_EMPTY     11
`define USMI_B_RX_DMA_BUF_FULL     12
`define USMI_B_ISO_NEGATIVE_ACK       13
`define USMI_B_CTS_EDGE_SEEN      19
`define USMI_B_MANCHESTER_FAULT_IRQ       20
`define USMI_B_CTS        23
`define USMI_B_MANCHESTER_FAULT_FLAG     24
`define USMI_IRQ_VALID    32'h01183fff

// control command bits
`define USMI_C_RXEN       4
`define USMI_C_RXDIS      5
`define USMI_C_TXEN       6
`define USMI_C_TXDIS      7
`define USMI_C_CLRERR     8
`define USMI_C_BRK        9

// mode register fields
`define USMI_F_MODE_HI    3
`define USMI_F_MODE_LO    0
`define USMI_F_SRC_HI     5
`define USMI_F_SRC_LO     4
`define USMI_F_CHAR_LENGTH_SEL_HI    7
`define USMI_F_CHAR_LENGTH_SEL_LO    6
`define USMI_F_NINE       17
`define USMI_MODE_VALID   32'h000200ff

// mode and clock source codes
`define USMI_M_NORMAL     4'h0
`define USMI_M_RS485      4'h1
`define USMI_M_HSHAKE     4'h2
`define USMI_M_ISO_T0     4'h4
`define USMI_M_ISO_T1     4'h6
`define USMI_M_IRDA       4'h8
`define USMI_M_SPI_MST    4'he
`define USMI_M_SPI_SLV    4'hf
`define USMI_S_INT        2'h0
`define USMI_S_DIV        2'h1
`define USMI_S_EXT        2'h3

// fixed divider and char lengths
`define USMI_DIV_LAST     3'h7
`define USMI_BITS_BASE    4'h5
`define USMI_BITS_NINE    4'h9

`endif

// *** core/usmi_pkg.sv ***
package usmi_pkg;

    // decoded operating mode
    typedef enum logic [3:0] {
        USMI_NORMAL,
        USMI_RS485,
        USMI_HSHAKE,
        USMI_ISO_T0,
        USMI_ISO_T1,
        USMI_IRDA,
        USMI_SPI_MASTER,
        USMI_SPI_SLAVE,
        USMI_RESERVED
    } usmi_mode_type;

    // register port request
    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } usmi_req_type;

    // events and levels from the serial engine
    typedef struct packed {
        logic       charDone;
        logic [8:0] charData;
        logic       breakSeen;
        logic       overrun;
        logic       framing;
        logic       parity;
        logic       manchester;
        logic       retryLimit;
        logic       iso_negative_ack;
        logic       timeout;
        logic       txDrained;
        logic       txLoaded;
        logic       breakStarted;
        logic       rxDmaDone;
        logic       txDmaDone;
        logic       rxDmaFull;
        logic       txDmaEmpty;
    } usmi_evt_type;

endpackage : usmi_pkg

// *** tb/usmi_sva.sv ***
`timescale 1ns/1ps

module usmi_sva
    import usmi_pkg::*;
(
    // clock and reset
    input wire logic         sys_clk,
    input wire logic         rst_n,
    // register port
    input wire usmi_req_type busReq,
    input wire logic [31:0]  busRdata,
    // line side and outputs
    input wire usmi_evt_type lineEvt,
    input wire logic         ctsPin,
    input wire logic [1:0]   baudSource,
    input wire logic [3:0]   dataBits,
    input wire logic         baudTick,
    input wire logic         irq
);
    // ----
    // shadow state
    // ----
    logic [31:0] shadowMask;
    logic [31:0] modeWord;
    logic [2:0]  ctsHist;

    // mask mirror; valid sources only
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            shadowMask <= 32'h0;
        else if (busReq.wr && busReq.addr == 8'h08)
            shadowMask <= shadowMask | (busReq.wdata & 32'h01183fff);
        else if (busReq.wr && busReq.addr == 8'h0c)
            shadowMask <= shadowMask & ~busReq.wdata;
    end

    // last mode word written
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            modeWord <= 32'h0;
        else if (busReq.wr && busReq.addr == 8'h04)
            modeWord <= busReq.wdata;
    end

    // pin history: judge the image on a settled pin
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            ctsHist <= 3'h0;
        else
            ctsHist <= {ctsHist[1:0], ctsPin};
    end

    // ----
    // properties
    // ----
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    sequence modeWr;
        busReq.wr && busReq.addr == 8'h04;
    endsequence

    rdata_idle_a:
        assert property (!busReq.rd |=> busRdata == 32'h0)
        else $error("read data not zero outside a read");
    wo_read_a:
        assert property (busReq.rd && busReq.addr[7:3] == 5'h01 |=> busRdata == 32'h0)
        else $error("write-only place read non-zero");
    mask_view_a:
        assert property (busReq.rd && busReq.addr == 8'h10 |=> busRdata == shadowMask)
        else $error("mask read differs from writes");
    no_irq_a:
        assert property (shadowMask == 32'h0 |=> !irq)
        else $error("interrupt with all sources masked");
    dma_irq_a:
        assert property ((shadowMask[12] && lineEvt.rxDmaFull)[*3] |-> irq)
        else $error("buffer full did not interrupt");
    char_len_a:
        assert property (modeWr |=> ##1
            dataBits == (modeWord[17] ? 4'h9 : 4'h5 + {2'h0, modeWord[7:6]}))
        else $error("data bits wrong");
    src_copy_a:
        assert property (modeWr |=> ##1 baudSource == modeWord[5:4])
        else $error("clock source wrong");
    tick_every_a:
        assert property ((baudSource == 2'h0)[*3] |-> baudTick)
        else $error("internal clock missed a tick");
    tick_never_a:
        assert property ((baudSource == 2'h2)[*3] |-> !baudTick)
        else $error("reserved clock ticked");
    div_gap_a:
        assert property (baudTick && baudSource == 2'h1 |=> (!baudTick)[*7])
        else $error("divided clock ticked early");
    cts_image_a:
        assert property (busReq.rd && busReq.addr == 8'h14 && ctsHist == {3{ctsPin}}
            |=> busRdata[23] == ctsHist[0])
        else $error("pin image wrong");
endmodule : usmi_sva

bind usmi_top usmi_sva u_usmi_sva (
    .sys_clk(sys_clk), .rst_n(rst_n), .busReq(busReq), .busRdata(busRdata),
    .lineEvt(lineEvt), .ctsPin(ctsPin), .baudSource(baudSource),
    .dataBits(dataBits), .baudTick(baudTick), .irq(irq)
);

// *** tb/usmi_peer.sv ***
`timescale 1ns/1ps

module usmi_peer
    import usmi_pkg::*;
(
    // clock and device outputs
    input wire logic     sys_clk,
    input wire logic     txCharValid,
    input wire logic     breakRequest,
    // line events and pins
    output usmi_evt_type lineEvt,
    output logic         ctsPin,
    output logic         extClkPin
);
    usmi_evt_type pulse;
    usmi_evt_type level;
    logic         txAck;
    logic         brkAck;
    int           holdCnt;
    int           ackDelay;

    // pins idle low; external clock kept off the system edges
    initial
    begin
        pulse = '0;
        level = '0;
        ctsPin = 1'b0;
        extClkPin = 1'b0;
        ackDelay = 1;
        holdCnt = 0;
        #10;
        forever #175 extClkPin = ~extClkPin;
    end

    // char taken after ackDelay cycles, break at once
    always @(posedge sys_clk)
    begin
        brkAck <= breakRequest && !brkAck;
        txAck <= txCharValid && !txAck && holdCnt >= ackDelay;
        if (txCharValid && !txAck)
            holdCnt <= (holdCnt >= ackDelay) ? 0 : holdCnt + 1;
    end

    // merge pulses, levels and acknowledges
    always_comb
    begin
        lineEvt = usmi_evt_type'(pulse | level);
        lineEvt.txLoaded = txAck === 1'b1;
        lineEvt.breakStarted = brkAck === 1'b1;
    end

    // one-cycle event, started just after an edge
    task automatic fire(input usmi_evt_type e);
        pulse <= e;
        @(posedge sys_clk);
        pulse <= '0;
    endtask : fire
endmodule : usmi_peer

// *** tb/test_usart_mode_and_interrupt_status.sv ***
`timescale 1ns/1ps

`define CHK(n, e, g) \
    begin \
        checks++; \
        if ((g) !== (e)) \
        begin \
            failures++; \
            $display("Error %s expected %h seen %h", n, e, g); \
        end \
    end

module test_usart_mode_and_interrupt_status
    import usmi_pkg::*;
;
    logic          sys_clk;
    logic          rst_n;
    usmi_req_type  busReq;
    logic [31:0]   busRdata;
    usmi_evt_type  lineEvt;
    logic          ctsPin;
    logic          extClkPin;
    usmi_mode_type opMode;
    logic [1:0]    baudSource;
    logic [3:0]    dataBits;
    logic          baudTick;
    logic          rxEnable;
    logic          txEnable;
    logic [8:0]    txChar;
    logic          txCharValid;
    logic          breakRequest;
    logic          irq;
    int            failures;
    int            checks;
    int            seed;
    int            mask;
    int            cnt;
    int            q[$];
    logic [31:0]   w;
    usmi_evt_type  ev;
    int            srcW[3] = '{32'h30, 32'h10, 32'h20};
    int            tickExp[3] = '{8, 7, 0};

    usmi_top u_usmi_top (
        .sys_clk(sys_clk), .rst_n(rst_n), .busReq(busReq), .busRdata(busRdata),
        .lineEvt(lineEvt), .ctsPin(ctsPin), .extClkPin(extClkPin), .opMode(opMode),
        .baudSource(baudSource), .dataBits(dataBits), .baudTick(baudTick),
        .rxEnable(rxEnable), .txEnable(txEnable), .txChar(txChar),
        .txCharValid(txCharValid), .breakRequest(breakRequest), .irq(irq)
    );

    usmi_peer u_usmi_peer (
        .sys_clk(sys_clk), .txCharValid(txCharValid), .breakRequest(breakRequest),
        .lineEvt(lineEvt), .ctsPin(ctsPin), .extClkPin(extClkPin)
    );

    // 20 MHz system clock
    initial
    begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    // ----
    // bus tasks and model
    // ----
    function automatic usmi_mode_type modeOf(input int c);
        case (c)
            0: return USMI_NORMAL;
            1: return USMI_RS485;
            2: return USMI_HSHAKE;
            4: return USMI_ISO_T0;
            6: return USMI_ISO_T1;
            8: return USMI_IRDA;
            14: return USMI_SPI_MASTER;
            15: return USMI_SPI_SLAVE;
            default: return USMI_RESERVED;
        endcase
    endfunction : modeOf

    // idle cycle after a strobe: one assignment per step
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        busReq <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
        @(posedge sys_clk);
        busReq <= '0;
        @(posedge sys_clk);
        if (a == 8'h08)
            mask = mask | (v & 32'h01183fff);
        if (a == 8'h0c)
            mask = mask & ~v;
    endtask : wr

    task automatic rdChk(input string n, input logic [7:0] a, input logic [31:0] m,
                         input logic [31:0] e);
        busReq <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge sys_clk);
        busReq <= '0;
        #1 `CHK(n, e, busRdata & m)
        @(posedge sys_clk);
    endtask : rdChk

    task automatic irqIs(input logic e);
        repeat (5) @(posedge sys_clk);
        #1 `CHK("irq", e, irq)
        @(posedge sys_clk);
    endtask : irqIs

    task automatic summarize();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : summarize

    // ----
    // scenarios
    // ----
    initial
    begin
        seed = 18;
        failures = 0;
        checks = 0;
        mask = 0;
        rst_n = 1'b0;
        busReq = '0;
        repeat (5) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        // reset, write-only and unmapped reads
        rdChk("mask", 8'h10, '1, 32'h0);
        rdChk("flags", 8'h14, '1, 32'h0);
        rdChk("ien", 8'h08, '1, 32'h0);
        rdChk("idis", 8'h0c, '1, 32'h0);
        rdChk("unmapped", 8'h40, '1, 32'h0);
        // random set and clear, some zero
        for (int i = 0; i < 24; i++)
        begin
            w = (i % 6 == 0) ? 32'h0 : $random(seed);
            wr(($random(seed) & 1) ? 8'h08 : 8'h0c, w);
            rdChk("mask", 8'h10, '1, mask);
        end
        // every mode code, sources 10/11
        for (int c = 0; c < 16; c++)
        begin
            w = $random(seed);
            w[3:0] = c[3:0];
            w[5] = 1'b1;
            wr(8'h04, w);
            rdChk("mode", 8'h04, '1, w & 32'h000200ff);
            `CHK("opMode", modeOf(c), opMode)
            `CHK("dataBits", w[17] ? 4'h9 : 4'h5 + 4'(w[7:6]), dataBits)
            `CHK("src", w[5:4], baudSource)
        end
        // ticks in 56 cycles: ext, divided, reserved
        for (int k = 0; k < 3; k++)
        begin
            wr(8'h04, srcW[k]);
            repeat (4) @(posedge sys_clk);
            cnt = 0;
            repeat (56)
            begin
                @(posedge sys_clk);
                #1 cnt += baudTick;
            end
            `CHK("ticks", tickExp[k], cnt)
            @(posedge sys_clk);
        end
        // manchester via both enables
        wr(8'h0c, 32'hffffffff);
        wr(8'h08, 32'h00100000);
        ev = '0;
        ev.manchester = 1'b1;
        u_usmi_peer.fire(ev);
        irqIs(1'b1);
        wr(8'h0c, 32'h00100000);
        irqIs(1'b0);
        wr(8'h08, 32'h01000000);
        irqIs(1'b1);
        ev = '0;
        ev.parity = 1'b1;
        ev.framing = 1'b1;
        ev.overrun = 1'b1;
        ev.breakSeen = 1'b1;
        ev.retryLimit = 1'b1;
        u_usmi_peer.fire(ev);
        rdChk("flags", 8'h14, '1, 32'h010004e4);
        wr(8'h00, 32'h100);
        rdChk("flags", 8'h14, '1, 32'h0);
        irqIs(1'b0);
        // pin change flag, cleared by the status read
        wr(8'h08, 32'h00080000);
        u_usmi_peer.ctsPin <= 1'b1;
        irqIs(1'b1);
        rdChk("flags", 8'h14, '1, 32'h00880000);
        rdChk("flags", 8'h14, '1, 32'h00800000);
        irqIs(1'b0);
        wr(8'h0c, 32'h00080000);
        // receive, read, then disable
        wr(8'h00, 32'h10);
        wr(8'h08, 32'h1);
        ev = '0;
        ev.charDone = 1'b1;
        ev.charData = 9'($random(seed));
        q.push_back(int'(ev.charData));
        u_usmi_peer.fire(ev);
        irqIs(1'b1);
        rdChk("rxdata", 8'h18, '1, q.pop_front());
        rdChk("flags", 8'h14, 32'h1, 32'h0);
        u_usmi_peer.fire(ev);
        wr(8'h00, 32'h20);
        rdChk("flags", 8'h14, 32'h1, 32'h0);
        // slow transmit, then break
        u_usmi_peer.ackDelay = 8;
        wr(8'h00, 32'h40);
        rdChk("flags", 8'h14, 32'h2, 32'h2);
        w = $random(seed);
        wr(8'h1c, w);
        rdChk("flags", 8'h14, 32'h2, 32'h0);
        `CHK("txChar", w[8:0], txChar)
        repeat (12) @(posedge sys_clk);
        rdChk("flags", 8'h14, 32'h2, 32'h2);
        wr(8'h00, 32'h200);
        rdChk("flags", 8'h14, 32'h2, 32'h0);
        // buffer levels as separate sources
        wr(8'h08, 32'h1800);
        u_usmi_peer.level.rxDmaFull <= 1'b1;
        irqIs(1'b1);
        u_usmi_peer.level.rxDmaFull <= 1'b0;
        u_usmi_peer.level.txDmaEmpty <= 1'b1;
        irqIs(1'b1);
        wr(8'h0c, 32'h800);
        irqIs(1'b0);
        summarize();
    end

    // watchdog, well past the run length
    initial
    begin
        repeat (5000) @(posedge sys_clk);
        failures++;
        summarize();
    end
endmodule : test_usart_mode_and_interrupt_status
